// ### logic/watch_compare.sv
`timescale 1ns/100ps
`default_nettype none
module watch_compare
  import watch_pkg::*;
(
  input wire logic [31:0] ref_addr,
  input wire logic [31:0] watch_addr,
  input wire logic [31:0] qual,
  input wire logic [7:0] ctx_id,
  output logic hit
);
  logic [ADDR_HI:ADDR_LO] diff;
  logic [ADDR_HI:ADDR_LO] care;
  genvar i;
  generate
    for (i = ADDR_LO; i <= ADDR_HI; i++) begin : g_bit
      // Mask covers only low bits; upper bits always compared
      if (i <= MASK_HI) begin : g_m
        assign care[i] = ~qual[i]; // RULE5
      end else begin : g_n
        assign care[i] = 1'b1;
      end
      assign diff[i] = (ref_addr[i] ^ watch_addr[i]) & care[i]; // RULE9
    end
  endgenerate
  // RULE3 RULE4
  assign hit = (diff == '0) && (qual[GLOBAL_BIT] || (qual[ID_HI:ID_LO] == ctx_id));
endmodule // watch_compare
`default_nettype wire

// ### logic/watch_match_unit.sv
`timescale 1ns/100ps
`default_nettype none
module watch_match_unit
  import watch_pkg::*;
#(
  parameter bit HAS_TLB = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic ADDR_WR,
  input wire logic QUAL_WR,
  input wire logic [31:0] WR_DATA,
  input wire logic [31:0] CONTEXT_REG,
  input wire logic EXC_LEVEL,
  input wire logic ERR_LEVEL,
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic LOAD_VALID,
  input wire logic STORE_VALID,
  input wire logic [31:0] DATA_ADDR,
  input wire logic PENDING_CLR,
  output logic [31:0] ADDR_RD,
  output logic [31:0] QUAL_RD,
  output logic WATCH_EXC,
  output logic WATCH_PENDING
);
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] qual;
    logic exc;
    logic pend;
  } state_s;
  state_s st_r;
  state_s st_nxt;
  logic fetch_hit;
  logic data_hit;
  logic fetch_match;
  logic load_match;
  logic store_match;
  logic any_match;
  logic pend_live;
  logic take_now;
  logic defer_now;
  logic levels_clear;
  logic [31:0] qual_mask;

  // Without translation the global and identifier bits can never be set
  assign qual_mask = HAS_TLB ? QUAL_RW_MASK : QUAL_NOTLB_MASK; // RULE7
  assign levels_clear = !EXC_LEVEL && !ERR_LEVEL; // RULE1

  watch_compare u_fetch (
    .ref_addr(FETCH_ADDR),
    .watch_addr(st_r.addr),
    .qual(st_r.qual),
    .ctx_id(CONTEXT_REG[CTX_ID_HI:CTX_ID_LO]),
    .hit(fetch_hit)
  );
  watch_compare u_data (
    .ref_addr(DATA_ADDR),
    .watch_addr(st_r.addr),
    .qual(st_r.qual),
    .ctx_id(CONTEXT_REG[CTX_ID_HI:CTX_ID_LO]),
    .hit(data_hit)
  );

  // Fetch and data paths compare in parallel, so both count in one cycle
  assign fetch_match = FETCH_VALID && st_r.addr[EN_FETCH] && fetch_hit; // RULE10
  assign load_match = LOAD_VALID && st_r.addr[EN_LOAD] && data_hit; // RULE10
  assign store_match = STORE_VALID && st_r.addr[EN_STORE] && data_hit; // RULE10
  assign any_match = fetch_match || load_match || store_match; // RULE11
  // A clear drops an old deferral; a new match in the same cycle still wins
  assign pend_live = st_r.pend && !PENDING_CLR; // RULE2
  assign take_now = (any_match || pend_live) && levels_clear; // RULE1
  assign defer_now = (any_match || pend_live) && !levels_clear; // RULE2

  always_comb begin
    st_nxt = st_r;
    st_nxt.exc = 1'b0;
    if (ADDR_WR) begin
      st_nxt.addr = WR_DATA; // RULE9
    end
    if (QUAL_WR) begin
      st_nxt.qual = WR_DATA & qual_mask; // RULE6 RULE7 RULE8
    end
    if (PENDING_CLR) begin
      st_nxt.pend = 1'b0;
    end
    if (take_now) begin
      st_nxt.exc = 1'b1; // RULE1
      st_nxt.pend = 1'b0;
    end
    if (defer_now) begin
      st_nxt.pend = 1'b1; // RULE2
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      // Address bits keep their value; qualifier cleared for a known readback
      st_r.addr[2:0] <= EN_RESET; // RULE10
      st_r.qual <= QUAL_RESET;
      st_r.exc <= 1'b0;
      st_r.pend <= 1'b0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign ADDR_RD = st_r.addr;
  // Qualifier is stored already masked, so readback needs no gating
  assign QUAL_RD = st_r.qual; // RULE6
  assign WATCH_EXC = st_r.exc;
  assign WATCH_PENDING = st_r.pend;

  pend_defer_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    CE && any_match && !levels_clear
    |=> WATCH_PENDING && !WATCH_EXC)
    else $error("match under level flags not deferred");

  exc_levels_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE1
    CE && (any_match || pend_live) && levels_clear
    |=> WATCH_EXC)
    else $error("watch exception not raised");

  qual_resv_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE6
    (QUAL_RD & ~qual_mask)
    == '0)
    else $error("reserved qualifier bits nonzero");

  en_reset_a: assert property (@(posedge CLOCK) // RULE10
    !RST_N
    |=> ADDR_RD[2:0] == EN_RESET && !WATCH_EXC && !WATCH_PENDING)
    else $error("enables or flags not cleared by reset");

  exc_cause_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE11
    CE && !any_match && !pend_live
    |=> !WATCH_EXC)
    else $error("watch exception without a match");

  exc_blocked_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE1
    CE && !levels_clear
    |=> !WATCH_EXC)
    else $error("watch exception under level flags");

  pend_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    CE && PENDING_CLR && !any_match
    |=> !WATCH_PENDING)
    else $error("pending flag not cleared");

  pend_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    CE && WATCH_PENDING && !levels_clear && !PENDING_CLR
    |=> WATCH_PENDING)
    else $error("pending flag dropped under level flags");

  pend_taken_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    CE && WATCH_PENDING && levels_clear && !PENDING_CLR
    |=> WATCH_EXC && !WATCH_PENDING)
    else $error("deferred watch exception not taken");

  exc_pend_excl_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    WATCH_EXC
    |-> !WATCH_PENDING)
    else $error("exception and pending flag set together");

  state_freeze_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE10
    !CE
    |=> $stable(QUAL_RD) && $stable(ADDR_RD[2:0])
      && $stable(WATCH_EXC) && $stable(WATCH_PENDING))
    else $error("state changed while clock enable low");

  qual_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE8
    CE && QUAL_WR
    |=> QUAL_RD == ($past(WR_DATA) & qual_mask))
    else $error("qualifier write not stored");

  addr_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE9
    CE && ADDR_WR
    |=> ADDR_RD == $past(WR_DATA))
    else $error("address write not stored");

  qual_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE8
    CE && !QUAL_WR
    |=> $stable(QUAL_RD))
    else $error("qualifier changed without a write");

  addr_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE10
    CE && !ADDR_WR
    |=> $stable(ADDR_RD[2:0]))
    else $error("reference enables changed without a write");

  global_match_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE3
    CE && FETCH_VALID && ADDR_RD[EN_FETCH] && QUAL_RD[GLOBAL_BIT] && levels_clear
      && FETCH_ADDR[ADDR_HI:ADDR_LO] == ADDR_RD[ADDR_HI:ADDR_LO]
    |=> WATCH_EXC)
    else $error("global watch match not raised");

  ident_block_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE4
    FETCH_VALID && !QUAL_RD[GLOBAL_BIT]
      && QUAL_RD[ID_HI:ID_LO] != CONTEXT_REG[CTX_ID_HI:CTX_ID_LO]
    |-> !fetch_hit)
    else $error("match despite identifier mismatch");

  mask_upper_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE5
    FETCH_ADDR[ADDR_HI:MASK_HI + 1] != ADDR_RD[ADDR_HI:MASK_HI + 1]
    |-> !fetch_hit)
    else $error("address bits above the mask ignored");

  data_en_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE10
    CE && !FETCH_VALID && !ADDR_RD[EN_LOAD] && !ADDR_RD[EN_STORE] && !pend_live
    |=> !WATCH_EXC)
    else $error("data reference matched while disabled");

  c_exc: cover property (@(posedge CLOCK) disable iff (!RST_N)
    WATCH_EXC);
  c_pend: cover property (@(posedge CLOCK) disable iff (!RST_N)
    WATCH_PENDING ##1 WATCH_EXC);
  c_fetch: cover property (@(posedge CLOCK) disable iff (!RST_N)
    FETCH_VALID && fetch_hit);
  c_data: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (LOAD_VALID || STORE_VALID) && data_hit);
  c_clear: cover property (@(posedge CLOCK) disable iff (!RST_N)
    WATCH_PENDING && PENDING_CLR ##1 !WATCH_PENDING);
endmodule // watch_match_unit
`default_nettype wire

// ### logic/watch_pkg.sv
// Notes on behaviour
// RULE1 - Exception only when both level flags clear
// RULE2 - Match under level flags sets pending, defers
// RULE3 - Global flag bit 30 ignores identifier
// RULE4 - Else identifier 23:16 must equal context
// RULE5 - Mask bits 11:3 exclude address bits
// RULE6 - Reserved qualifier bits read zero
// RULE7 - Without translation buffer, global and identifier zero
// RULE8 - Global, identifier, mask read/write, reset undefined; here reset clears them to zero (QUAL_RESET)
// RULE9 - Address bits 31:3 compared with reference
// RULE10 - Fetch, load, store enables cleared on reset
// RULE11 - Match needs enable, address and identifier
package watch_pkg;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 3;
  localparam int EN_FETCH = 2;
  localparam int EN_LOAD = 1;
  localparam int EN_STORE = 0;
  localparam int GLOBAL_BIT = 30;
  localparam int ID_HI = 23;
  localparam int ID_LO = 16;
  localparam int MASK_HI = 11;
  localparam int MASK_LO = 3;
  localparam int CTX_ID_HI = 7;
  localparam int CTX_ID_LO = 0;
  localparam logic [2:0] EN_RESET = 3'h0;
  localparam logic [31:0] QUAL_RESET = 32'h00000000;
  localparam logic [31:0] QUAL_RW_MASK = 32'h40ff0ff8;
  localparam logic [31:0] QUAL_NOTLB_MASK = 32'h00000ff8;
endpackage

// ### tb/ref_pipe.sv
`timescale 1ns/100ps
`default_nettype none
module ref_pipe (
  input wire logic clk,
  output logic fv,
  output logic lv,
  output logic sv,
  output logic [31:0] fa,
  output logic [31:0] da
);
  initial {fv, lv, sv, fa, da} = '0;
  // Address is scrambled after use so a stale value never matches
  task automatic go(input logic [2:0] k, input logic [31:0] a);
    @(posedge clk) #1;
    {fv, lv, sv} = k;
    fa = a;
    da = a;
    @(posedge clk) #1;
    {fv, lv, sv} = 3'h0;
    fa = ~a;
    da = ~a;
  endtask
endmodule // ref_pipe
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, aw = 0, qw = 0, exception_level_flag = 0, error_level_flag = 0, ce = 1, pclr = 0;
  logic [31:0] wd = '0, ctx = '0, ard, qrd, fa, da;
  logic fv, lv, sv, exc, pend;
  int n_errors = 0, check_count = 0;
  always #2 clk = ~clk;
  ref_pipe i_ref_pipe (.clk(clk), .fv(fv), .lv(lv), .sv(sv), .fa(fa), .da(da));
  watch_match_unit i_watch_match_unit (.CLOCK(clk), .RST_N(rst_n), .CE(ce),
    .ADDR_WR(aw), .QUAL_WR(qw), .WR_DATA(wd), .CONTEXT_REG(ctx), .EXC_LEVEL(exception_level_flag),
    .ERR_LEVEL(error_level_flag), .FETCH_VALID(fv), .FETCH_ADDR(fa), .LOAD_VALID(lv),
    .STORE_VALID(sv), .DATA_ADDR(da), .PENDING_CLR(pclr), .ADDR_RD(ard),
    .QUAL_RD(qrd), .WATCH_EXC(exc), .WATCH_PENDING(pend));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic a, input logic [31:0] d);
    @(posedge clk) #1;
    aw = a;
    qw = !a;
    wd = d;
    @(posedge clk) #1;
    aw = 0;
    qw = 0;
  endtask
  task automatic hit(input logic [2:0] k, input logic [31:0] a, input logic [1:0] ep);
    i_ref_pipe.go(k, a);
    chk("exc_pend", {30'h0, ep}, {30'h0, exc, pend});
  endtask
  task automatic t_regs;
    chk("en", 32'h0, {29'h0, ard[2:0]});
    wr(0, 32'hffffffff);
    chk("qual", 32'h40ff0ff8, qrd);
    wr(1, 32'h10000007);
    chk("addr", 32'h10000007, ard);
    $display("t_regs done");
  endtask
  task automatic t_match;
    wr(0, 32'h40000000);
    ctx = 32'h000000aa;
    for (int i = 0; i < 3; i++) hit(3'h1 << i, 32'h10000000, 2'b10);
    hit(3'h4, 32'h10000008, 2'b00);
    wr(1, 32'h10000006);
    hit(3'h1, 32'h10000000, 2'b00);
    wr(0, 32'h40000ff8);
    chk("qual", 32'h40000ff8, qrd);
    hit(3'h4, 32'h10000ff8, 2'b10);
    hit(3'h4, 32'h10001000, 2'b00);
    $display("t_match done");
  endtask
  task automatic t_ident;
    wr(0, 32'h00aa0000);
    ctx = 32'h000000ab;
    hit(3'h4, 32'h10000000, 2'b00);
    ctx = 32'h000000aa;
    hit(3'h4, 32'h10000000, 2'b10);
    $display("t_ident done");
  endtask
  task automatic t_defer;
    exception_level_flag = 1;
    hit(3'h2, 32'h10000000, 2'b01);
    error_level_flag = 1;
    exception_level_flag = 0;
    @(posedge clk) #1;
    chk("exc_pend", 32'h1, {30'h0, exc, pend});
    error_level_flag = 0;
    @(posedge clk) #1;
    chk("exc_pend", 32'h2, {30'h0, exc, pend});
    $display("t_defer done");
  endtask
  task automatic t_ctrl;
    exception_level_flag = 1;
    hit(3'h2, 32'h10000000, 2'b01);
    @(posedge clk) #1;
    pclr = 1;
    @(posedge clk) #1;
    pclr = 0;
    exception_level_flag = 0;
    chk("exc_pend", 32'h0, {30'h0, exc, pend});
    @(posedge clk) #1;
    chk("exc_pend", 32'h0, {30'h0, exc, pend});
    ce = 0;
    hit(3'h2, 32'h10000000, 2'b00);
    wr(0, 32'h40000000);
    chk("qual", 32'h00aa0000, qrd);
    ce = 1;
    @(posedge clk) #1;
    rst_n = 0;
    @(posedge clk) #1;
    rst_n = 1;
    chk("en", 32'h0, {29'h0, ard[2:0]});
    chk("qual", 32'h0, qrd);
    hit(3'h2, 32'h10000000, 2'b00);
    $display("t_ctrl done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    t_regs();
    t_match();
    t_ident();
    t_defer();
    t_ctrl();
    give_verdict();
  end
  // Tests take under 100 cycles; a hang is cut well beyond that
  initial begin
    #4000;
    n_errors++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
